// file: hdl/iep_pkg.sv
// package for the interrupt enable and priority block
// assumes a byte-wide register map reached over a 32-bit wishbone slave
package iep_pkg;

	// ----------------------------------------
	// register indices and address width
	// ----------------------------------------
	localparam logic [11:0] IEP_IDX_ENABLE_HI = 12'h0fc1; // group0 enable high
	localparam logic [11:0] IEP_IDX_ENABLE_LO = 12'h0fc2; // group0 enable low
	localparam logic [11:0] IEP_IDX_CONTROL = 12'h0fcf; // interrupt control
	localparam logic [11:0] IEP_IDX_STATUS = 12'h0fd0; // sticky event status
	localparam logic [11:0] IEP_IDX_MASK = 12'h0fd1; // event mask
	localparam int IEP_ADDR_W = 14;

	// ----------------------------------------
	// field positions and reset values
	// ----------------------------------------
	localparam int IEP_CTL_GIE_BIT = 7; // global enable in control register
	localparam int IEP_EVT_ACK_BIT = 0; // request acknowledged by core
	localparam int IEP_EVT_GIE_OFF_BIT = 1; // global enable dropped
	localparam int IEP_EVT_W = 2;
	localparam logic [7:0] IEP_ENABLE_RST = 8'h00;
	localparam logic [1:0] IEP_EVT_RST = 2'h0;

	// ----------------------------------------
	// source bit positions in group 0
	// ----------------------------------------
	// source bit map
	localparam int IEP_SRC_TIMER2 = 7;
	localparam int IEP_SRC_TIMER1 = 6;
	localparam int IEP_SRC_TIMER0 = 5;
	localparam int IEP_SRC_UART0_RX = 4;
	localparam int IEP_SRC_UART0_TX = 3;
	localparam int IEP_SRC_TWOWIRE = 2;
	localparam int IEP_SRC_SPI = 1;
	localparam int IEP_SRC_ADC = 0;

	// ----------------------------------------
	// priority levels
	// ----------------------------------------
	typedef enum logic [1:0] {
		IEP_PRIO_OFF = 2'b00,
		IEP_PRIO_LOW = 2'b01,
		IEP_PRIO_NOM = 2'b10,
		IEP_PRIO_HIGH = 2'b11
	} iep_prio_t;

endpackage

// file: hdl/iep_prio_pick.sv
// priority picker: highest level pending request, higher bit wins ties
// assumes request, enable high and enable low vectors of equal width
`timescale 1ns/1ps
module iep_prio_pick
	import iep_pkg::*;
(
	// vectors in
	input wire logic [7:0] req_i,
	input wire logic [7:0] en_hi_i,
	input wire logic [7:0] en_lo_i,
	// choice out
	output logic found_o,
	output logic [2:0] index_o,
	output iep_prio_t level_o
);

	// ----------------------------------------
	// scan from bit 0 upward, ties go to later bit
	// ----------------------------------------
	always_comb
	begin
		found_o = 1'b0;
		index_o = 3'h0;
		level_o = IEP_PRIO_OFF;
		for (int i = 0; i < 8; i++)
		begin
			if (req_i[i] && ({en_hi_i[i], en_lo_i[i]} != IEP_PRIO_OFF) &&
				({en_hi_i[i], en_lo_i[i]} >= level_o))
			begin
				found_o = 1'b1;
				index_o = 3'(i);
				level_o = iep_prio_t'({en_hi_i[i], en_lo_i[i]});
			end
		end
	end

endmodule

// file: hdl/iep_core.sv
// interrupt enable and group 0 priority controller with wishbone slave
// assumes core instruction strobes and peripheral requests synchronous to clk_i
//
// Summary of operation
// - one global enable bit in control register, gates requests, cleared by reset
// - enable instruction sets the global enable
// - return-from-interrupt instruction sets the global enable
// - writing one to the global enable bit sets it
// - disable instruction clears the global enable
// - core acknowledge of a request clears the global enable
// - writing zero to the global enable bit clears it
// - two enable bits per source give off, low, nominal, high priority
// - encoding applies to each request bit separately, bit x with bit x
// - bits 7..0: timer2, timer1, timer0, uart rx, uart tx, twowire, spi, adc
//
// The Wishbone register port was left to the implementer.
`timescale 1ns/1ps
module iep_core
	import iep_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [IEP_ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	output logic wb_err_o,
	// core side
	input wire logic enable_irq_instr_i,
	input wire logic disable_irq_instr_i,
	input wire logic return_from_irq_instr_i,
	input wire logic irq_ack_i,
	output logic irq_req_o,
	output logic [2:0] irq_index_o,
	output logic [1:0] irq_level_o,
	// peripheral requests, one bit per source
	input wire logic [7:0] request_group0_i,
	// summary interrupt
	output logic irq_o
);

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic global_irq_enable_q;
	logic global_irq_enable_d;
	logic [7:0] group0_enable_hi_q;
	logic [7:0] group0_enable_lo_q;
	logic [IEP_EVT_W-1:0] evt_status_q;
	logic [IEP_EVT_W-1:0] evt_status_d;
	logic [IEP_EVT_W-1:0] evt_mask_q;
	logic ack_q;
	logic err_q;
	logic [31:0] rdata_q;
	logic req_q;
	logic [2:0] index_q;
	logic [1:0] level_q;

	// ----------------------------------------
	// bus decode
	// ----------------------------------------
	// word address match for one register index
	function automatic logic hit(input logic [IEP_ADDR_W-1:0] adr, input logic [11:0] idx);
		hit = (adr == {idx, 2'b00});
	endfunction

	wire bus_req = wb_cyc_i && wb_stb_i && !ack_q && !err_q;
	wire sel_hi = hit(wb_adr_i, IEP_IDX_ENABLE_HI);
	wire sel_lo = hit(wb_adr_i, IEP_IDX_ENABLE_LO);
	wire sel_ctl = hit(wb_adr_i, IEP_IDX_CONTROL);
	wire sel_st = hit(wb_adr_i, IEP_IDX_STATUS);
	wire sel_mk = hit(wb_adr_i, IEP_IDX_MASK);
	wire mapped = sel_hi || sel_lo || sel_ctl || sel_st || sel_mk;
	wire wr_lane0 = bus_req && mapped && wb_we_i && wb_sel_i[0];
	wire rd_status = bus_req && sel_st && !wb_we_i;

	// read mux, upper bits zero
	wire [7:0] rd_byte = sel_hi ? group0_enable_hi_q :
		sel_lo ? group0_enable_lo_q :
		sel_ctl ? {global_irq_enable_q, 7'h00} :
		sel_st ? {6'h00, evt_status_q} :
		sel_mk ? {6'h00, evt_mask_q} : 8'h00;

	// ----------------------------------------
	// priority pick
	// ----------------------------------------
	logic pick_found;
	logic [2:0] pick_index;
	iep_prio_t pick_level;

	iep_prio_pick u_pick (
		.req_i(request_group0_i),
		.en_hi_i(group0_enable_hi_q),
		.en_lo_i(group0_enable_lo_q),
		.found_o(pick_found),
		.index_o(pick_index),
		.level_o(pick_level)
	);

	// ----------------------------------------
	// global enable next value
	// ----------------------------------------
	wire gie_wr = wr_lane0 && sel_ctl;
	wire gie_set = enable_irq_instr_i || return_from_irq_instr_i ||
		(gie_wr && wb_dat_i[IEP_CTL_GIE_BIT]);
	wire gie_clr = disable_irq_instr_i || (irq_ack_i && req_q) ||
		(gie_wr && !wb_dat_i[IEP_CTL_GIE_BIT]);

	// clear wins so a taken request cannot nest on the same edge
	always_comb
	begin
		global_irq_enable_d = global_irq_enable_q;
		if (gie_set)
			global_irq_enable_d = 1'b1;
		if (gie_clr)
			global_irq_enable_d = 1'b0;
	end

	// ----------------------------------------
	// event status: set wins over read clear
	// ----------------------------------------
	wire [IEP_EVT_W-1:0] evt_set = {global_irq_enable_q && !global_irq_enable_d,
		irq_ack_i && req_q};
	assign evt_status_d = (rd_status ? IEP_EVT_RST : evt_status_q) | evt_set;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			global_irq_enable_q <= 1'b0;
		else
			global_irq_enable_q <= global_irq_enable_d;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			group0_enable_hi_q <= IEP_ENABLE_RST;
			group0_enable_lo_q <= IEP_ENABLE_RST;
		end
		else
		begin
			if (wr_lane0 && sel_hi)
				group0_enable_hi_q <= wb_dat_i[7:0];
			if (wr_lane0 && sel_lo)
				group0_enable_lo_q <= wb_dat_i[7:0];
		end
	end

	// status and mask
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			evt_status_q <= IEP_EVT_RST;
			evt_mask_q <= IEP_EVT_RST;
		end
		else
		begin
			evt_status_q <= evt_status_d;
			if (wr_lane0 && sel_mk)
				evt_mask_q <= wb_dat_i[IEP_EVT_W-1:0];
		end
	end

	// bus answer one cycle after request, err on unmapped
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
		end
		else
		begin
			ack_q <= bus_req && mapped;
			err_q <= bus_req && !mapped;
			rdata_q <= {24'h00_0000, rd_byte};
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			req_q <= 1'b0;
			index_q <= 3'h0;
			level_q <= 2'h0;
		end
		else
		begin
			req_q <= global_irq_enable_d && pick_found;
			index_q <= pick_index;
			level_q <= pick_level;
		end
	end

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;
	assign wb_dat_o = rdata_q;
	assign irq_req_o = req_q;
	assign irq_index_o = index_q;
	assign irq_level_o = level_q;
	assign irq_o = |(evt_status_q & evt_mask_q);

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	// global enable sources
	AST_RESET_CLEARS: assert property (@(posedge clk_i) rst_i |=> !global_irq_enable_q)
		else $error("global enable not cleared by reset");
	AST_EI_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
		(enable_irq_instr_i && !gie_clr) |=> global_irq_enable_q)
		else $error("enable instruction did not set global enable");
	AST_RETURN_FROM_IRQ_INSTR_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
		(return_from_irq_instr_i && !gie_clr) |=> global_irq_enable_q)
		else $error("return instruction did not set global enable");
	AST_WR1_SETS: assert property (@(posedge clk_i) disable iff (rst_i)
		(gie_wr && wb_dat_i[IEP_CTL_GIE_BIT] && !disable_irq_instr_i &&
		!(irq_ack_i && req_q)) |=> global_irq_enable_q)
		else $error("write of one did not set global enable");
	AST_DI_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
		disable_irq_instr_i |=> !global_irq_enable_q && !irq_req_o)
		else $error("disable instruction did not clear global enable");
	AST_ACK_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
		(irq_ack_i && irq_req_o) |=> !global_irq_enable_q ##0 evt_status_q[IEP_EVT_ACK_BIT])
		else $error("acknowledge did not clear global enable");
	AST_WR0_CLEARS: assert property (@(posedge clk_i) disable iff (rst_i)
		(gie_wr && !wb_dat_i[IEP_CTL_GIE_BIT]) |=> !global_irq_enable_q)
		else $error("write of zero did not clear global enable");

	// priority and presentation
	AST_GATED: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_req_o |-> $past(global_irq_enable_d) && $past(pick_found))
		else $error("request presented while gated");
	AST_LEVEL: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_req_o |-> irq_level_o == $past({group0_enable_hi_q[pick_index],
		group0_enable_lo_q[pick_index]}) && irq_level_o != 2'b00)
		else $error("presented level does not match enable bits");
	AST_PER_BIT: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_req_o |-> $past(request_group0_i[pick_index]))
		else $error("presented source was not requesting");

	// register writes and top bit priority
	AST_HI_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lane0 && sel_hi) |=> group0_enable_hi_q == $past(wb_dat_i[7:0]))
		else $error("enable high write lost");
	AST_LO_WRITE: assert property (@(posedge clk_i) disable iff (rst_i)
		(wr_lane0 && sel_lo) |=> group0_enable_lo_q == $past(wb_dat_i[7:0]))
		else $error("enable low write lost");
	AST_HIGHEST: assert property (@(posedge clk_i) disable iff (rst_i)
		(pick_found && request_group0_i[IEP_SRC_TIMER2] &&
		group0_enable_hi_q[IEP_SRC_TIMER2] && group0_enable_lo_q[IEP_SRC_TIMER2])
		|-> pick_index == 3'(IEP_SRC_TIMER2))
		else $error("top bit at high level did not win");

	// register reset and hold
	AST_HI_RESET: assert property (@(posedge clk_i)
		rst_i |=> group0_enable_hi_q == IEP_ENABLE_RST)
		else $error("enable high not cleared by reset");
	AST_LO_RESET: assert property (@(posedge clk_i)
		rst_i |=> group0_enable_lo_q == IEP_ENABLE_RST)
		else $error("enable low not cleared by reset");
	AST_HI_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wr_lane0 && sel_hi) |=> $stable(group0_enable_hi_q))
		else $error("enable high changed without a write");
	AST_LO_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
		!(wr_lane0 && sel_lo) |=> $stable(group0_enable_lo_q))
		else $error("enable low changed without a write");

	// global enable and presentation
	AST_GIE_HOLDS: assert property (@(posedge clk_i) disable iff (rst_i)
		(!gie_set && !gie_clr) |=> $stable(global_irq_enable_q))
		else $error("global enable changed with no source");
	AST_REQ_NEEDS_GIE: assert property (@(posedge clk_i) disable iff (rst_i)
		irq_req_o |-> global_irq_enable_q)
		else $error("request presented with global enable low");
	AST_IDLE_NO_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
		(!global_irq_enable_d || !pick_found) |=> !irq_req_o)
		else $error("request presented while gated or idle");
	AST_FOUND_PRESENTED: assert property (@(posedge clk_i) disable iff (rst_i)
		(global_irq_enable_d && pick_found) |=> irq_req_o && irq_index_o == $past(pick_index))
		else $error("pending enabled request not presented");
	AST_EI_REQ: assert property (@(posedge clk_i) disable iff (rst_i)
		(enable_irq_instr_i && !gie_clr && pick_found) |=> irq_req_o)
		else $error("enable instruction did not present pending request");
	AST_IRQ_OUT: assert property (@(posedge clk_i) disable iff (rst_i)
		(irq_ack_i && irq_req_o && evt_mask_q[IEP_EVT_ACK_BIT] && !(wr_lane0 && sel_mk)) |=> irq_o)
		else $error("unmasked acknowledge event did not raise interrupt");

endmodule

// file: dv/iep_cpu_model.sv
// core side model: acknowledges a presented request after a set wait
// assumes irq_req_i registered on clk_i, ack taken while request is high
`timescale 1ns/1ps
module iep_cpu_model
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// control from bench
	input wire logic ack_en_i,
	input wire logic [3:0] wait_i,
	// core port
	input wire logic irq_req_i,
	output logic irq_ack_o
);
	logic [3:0] cnt_q;

	// count wait cycles, then one ack pulse
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !irq_req_i || !ack_en_i || irq_ack_o)
		begin
			cnt_q <= 4'h0;
			irq_ack_o <= 1'b0;
		end
		else
		begin
			cnt_q <= cnt_q + 4'h1;
			irq_ack_o <= (cnt_q == wait_i);
		end
	end
endmodule

// file: dv/iep_core_test.sv
// bench for the interrupt enable and priority block
// assumes wishbone answers with ack or err, core model acks requests
`timescale 1ns/1ps
module interrupt_enable_priority_test;
	import iep_pkg::*;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [IEP_ADDR_W-1:0] adr = '0;
	logic [3:0] sel = 4'hf;
	logic [31:0] wdat = 32'h0000_0000;
	logic [31:0] rdat;
	logic ack, err, irq_req, irq_ack, irq;
	logic ei = 1'b0;
	logic di = 1'b0;
	logic ret = 1'b0;
	logic ack_en = 1'b0;
	logic [3:0] wt = 4'h0;
	logic [7:0] req = 8'h00;
	logic [2:0] idx;
	logic [1:0] lvl;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;

	iep_core u_iep_core (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .wb_err_o(err), .enable_irq_instr_i(ei), .disable_irq_instr_i(di),
		.return_from_irq_instr_i(ret), .irq_ack_i(irq_ack), .irq_req_o(irq_req),
		.irq_index_o(idx), .irq_level_o(lvl), .request_group0_i(req), .irq_o(irq));
	iep_cpu_model u_iep_cpu_model (.clk_i(clk_i), .rst_i(rst_i), .ack_en_i(ack_en),
		.wait_i(wt), .irq_req_i(irq_req), .irq_ack_o(irq_ack));

	// clock and hang guard
	initial
	begin
		forever #2 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			miscompares++;
			stop_test();
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("tests %0d miscompares %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	// one classic cycle, held until ack or err
	task automatic bus(input logic w, input logic [11:0] i, input logic [7:0] d,
		output logic [31:0] q, output logic e);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {i, 2'b00};
		wdat <= {24'h00_0000, d};
		do @(posedge clk_i); while (ack !== 1'b1 && err !== 1'b1);
		q = rdat;
		e = err;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] i, input logic [7:0] d);
		logic [31:0] q;
		logic e;
		bus(1'b1, i, d, q, e);
	endtask

	task automatic rd(input logic [11:0] i, input logic [7:0] x);
		logic [31:0] q;
		logic e;
		bus(1'b0, i, 8'h00, q, e);
		chk(q, {24'h00_0000, x});
	endtask

	// one-cycle pulse: 0 enable, 1 disable, 2 return
	task automatic pulse(input int k);
		@(posedge clk_i);
		{ei, di, ret} <= 3'b100 >> k;
		@(posedge clk_i);
		{ei, di, ret} <= 3'b000;
	endtask

	task automatic see_irq(input logic r, input logic [2:0] i, input logic [1:0] l);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq_req}, {31'h0, r});
		if (r)
			chk({27'h0, idx, lvl}, {27'h0, i, l});
	endtask

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial
	begin
		logic [31:0] q;
		logic e;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(IEP_IDX_ENABLE_HI, 8'h00);
		rd(IEP_IDX_ENABLE_LO, 8'h00);
		rd(IEP_IDX_CONTROL, 8'h00);
		// unmapped place is refused
		bus(1'b0, 12'h0fc5, 8'h00, q, e);
		chk({31'h0, e}, 32'h0000_0001);
		wr(IEP_IDX_ENABLE_HI, 8'h5a);
		rd(IEP_IDX_ENABLE_HI, 8'h5a);
		wr(IEP_IDX_ENABLE_LO, 8'ha5);
		rd(IEP_IDX_ENABLE_LO, 8'ha5);
		wr(IEP_IDX_CONTROL, 8'h80);
		rd(IEP_IDX_CONTROL, 8'h80);
		wr(IEP_IDX_CONTROL, 8'h00);
		rd(IEP_IDX_CONTROL, 8'h00);
		pulse(0);
		rd(IEP_IDX_CONTROL, 8'h80);
		pulse(1);
		rd(IEP_IDX_CONTROL, 8'h00);
		pulse(2);
		rd(IEP_IDX_CONTROL, 8'h80);
		// every level code on the uart transmit bit
		req <= 8'hff;
		for (int l = 0; l < 4; l++)
		begin
			wr(IEP_IDX_ENABLE_HI, {4'h0, l[1], 3'h0});
			wr(IEP_IDX_ENABLE_LO, {4'h0, l[0], 3'h0});
			see_irq(l != 0, 3'(IEP_SRC_UART0_TX), l[1:0]);
		end
		// tie at level 3 on bits 6 and 2, bit 7 only low
		wr(IEP_IDX_ENABLE_HI, 8'h44);
		wr(IEP_IDX_ENABLE_LO, 8'hc4);
		see_irq(1'b1, 3'(IEP_SRC_TIMER1), IEP_PRIO_HIGH);
		// timer 2 raised to level 3 now takes the top bit
		wr(IEP_IDX_ENABLE_HI, 8'hc4);
		see_irq(1'b1, 3'(IEP_SRC_TIMER2), IEP_PRIO_HIGH);
		req <= 8'h04;
		see_irq(1'b1, 3'(IEP_SRC_TWOWIRE), IEP_PRIO_HIGH);
		pulse(1);
		see_irq(1'b0, 3'h0, 2'h0);
		rd(IEP_IDX_STATUS, 8'h02);
		// prompt then slow acknowledge from the core
		wr(IEP_IDX_MASK, 8'h03);
		ack_en <= 1'b1;
		pulse(0);
		repeat (6) @(posedge clk_i);
		rd(IEP_IDX_CONTROL, 8'h00);
		chk({31'h0, irq}, 32'h0000_0001);
		rd(IEP_IDX_STATUS, 8'h03);
		repeat (2) @(posedge clk_i);
		chk({31'h0, irq}, 32'h0000_0000);
		wt <= 4'h3;
		pulse(2);
		see_irq(1'b1, 3'(IEP_SRC_TWOWIRE), IEP_PRIO_HIGH);
		repeat (8) @(posedge clk_i);
		rd(IEP_IDX_CONTROL, 8'h00);
		// mid-run reset with global enable and enables set
		ack_en <= 1'b0;
		pulse(0);
		rd(IEP_IDX_CONTROL, 8'h80);
		rst_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(IEP_IDX_CONTROL, 8'h00);
		rd(IEP_IDX_ENABLE_HI, 8'h00);
		rd(IEP_IDX_ENABLE_LO, 8'h00);
		stop_test();
	end
endmodule
